//--- rtl/btf_exec.sv
// Execute unit for bit-invert, branch-on-overflow, branch-on-zero.
// Assumes instr is stable for a whole cycle and the core supplies
// read data in Q2 for the address resolved in Q1 and presented from Q2.
`timescale 1ns/1ps
module btf_exec
   import btf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [15:0] instr,
   input wire logic instr_valid,
   input wire logic [btf_pkg::BTF_PC_W-1:0] pc_next,
   input wire logic [3:0] bank_select_reg,
   input wire logic ext_set_en,
   input wire logic [btf_pkg::BTF_ADDR_W-1:0] index_base,
   input wire logic flag_ovf,
   input wire logic flag_zero,
   input wire logic [7:0] rd_data,
   output logic [btf_pkg::BTF_ADDR_W-1:0] reg_addr,
   output logic rd_en,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic pc_load,
   output logic [btf_pkg::BTF_PC_W-1:0] pc_target,
   output logic stall,
   output logic [1:0] phase_out
);
   // ---------------------------------------------------------
   // Phase sequencer
   // ---------------------------------------------------------
   btf_phase_e phase;
   btf_phase u_phase (
      .clk_sys(clk_sys),
      .rst(rst),
      .phase(phase)
   );
   assign phase_out = phase;

   // ---------------------------------------------------------
   // Decode
   // ---------------------------------------------------------
   function automatic logic is_invert(input logic [15:0] w);
      is_invert = (w[15:12] == BTF_OP_INVERT); // [RQ1]
   endfunction
   function automatic logic is_br_ovf(input logic [15:0] w);
      is_br_ovf = (w[15:8] == BTF_OP_OVF_BR); // [RQ6]
   endfunction
   function automatic logic is_br_zero(input logic [15:0] w);
      is_br_zero = (w[15:8] == BTF_OP_ZERO_BR); // [RQ10]
   endfunction

   // Operand address resolution, three addressing cases
   function automatic logic [BTF_ADDR_W-1:0] resolve(
      input logic [15:0] w, input logic ext, input logic [3:0] bank,
      input logic [BTF_ADDR_W-1:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (!w[BTF_A_BIT] && ext && f <= BTF_IDX_MAX) begin
         resolve = base + {4'h0, f}; // [RQ4]
      end else if (!w[BTF_A_BIT]) begin
         // Low part of access bank in bank 0, high in top bank
         resolve = (f < BTF_ACC_SPLIT) ? {4'h0, f}
                 : {BTF_ACC_HI_BANK, f}; // [RQ3]
      end else begin
         resolve = {bank, f}; // [RQ3]
      end
   endfunction

   // ---------------------------------------------------------
   // Sequencing state
   // ---------------------------------------------------------
   btf_state_e state_ff, nxt_state;
   logic [BTF_ADDR_W-1:0] addr_ff, nxt_addr;
   logic [2:0] bit_ff, nxt_bit;
   logic [7:0] wdat_ff, nxt_wdat;
   logic [BTF_PC_W-1:0] tgt_ff, nxt_tgt;
   logic take_ff, nxt_take;
   logic wr_ff, nxt_wr;
   logic pcl_ff, nxt_pcl;

   logic [BTF_PC_W-1:0] offs2;
   assign offs2 = {{(BTF_PC_W-9){instr[7]}}, instr[7:0], 1'b0};

   always_comb begin
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_bit = bit_ff;
      nxt_wdat = wdat_ff;
      nxt_tgt = tgt_ff;
      nxt_take = take_ff;
      nxt_wr = 1'b0;
      nxt_pcl = 1'b0;
      unique case (state_ff)
         btf_idle: begin
            if (phase == btf_q1 && instr_valid) begin
               if (is_invert(instr)) begin
                  nxt_state = btf_inv;
                  nxt_addr = resolve(instr, ext_set_en,
                     bank_select_reg, index_base);
                  nxt_bit = instr[BTF_BIT_LO+2:BTF_BIT_LO];
               end else if (is_br_ovf(instr) || is_br_zero(instr)) begin
                  nxt_state = btf_br_taken;
                  // Target: incremented PC plus twice offset
                  nxt_tgt = pc_next + offs2; // [RQ7] [RQ11]
               end
            end
         end
         btf_inv: begin
            if (phase == btf_q2) begin
               // Only the chosen bit flips; no flag path exists
               nxt_wdat = rd_data ^ (8'h01 << bit_ff); // [RQ2]
            end
            if (phase == btf_q3) begin
               nxt_wr = 1'b1; // [RQ5]
            end
            if (phase == btf_q4) begin
               nxt_state = btf_idle;
            end
         end
         btf_br_taken: begin
            if (phase == btf_q2) begin
               // Flags as held entering the processing phase
               nxt_take = is_br_ovf(instr) ? flag_ovf
                        : flag_zero; // [RQ12]
            end
            if (phase == btf_q3) begin
               nxt_pcl = take_ff; // [RQ7] [RQ11]
            end
            if (phase == btf_q4) begin
               nxt_state = take_ff ? btf_br_flush
                         : btf_idle; // [RQ8] [RQ9]
            end
         end
         btf_br_flush: begin
            if (phase == btf_q4) begin
               nxt_state = btf_idle; // [RQ8]
               nxt_take = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_ff <= btf_idle;
         addr_ff <= '0;
         bit_ff <= 3'h0;
         wdat_ff <= 8'h00;
         tgt_ff <= '0;
         take_ff <= 1'b0;
         wr_ff <= 1'b0;
         pcl_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         bit_ff <= nxt_bit;
         wdat_ff <= nxt_wdat;
         tgt_ff <= nxt_tgt;
         take_ff <= nxt_take;
         wr_ff <= nxt_wr;
         pcl_ff <= nxt_pcl;
      end
   end

   // ---------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------
   assign reg_addr = addr_ff;
   assign rd_en = (state_ff == btf_inv) && (phase == btf_q2);
   assign wr_en = wr_ff; // Q4 write of the register
   assign wr_data = wdat_ff;
   assign pc_load = pcl_ff; // Q4 write to PC, else sequential [RQ9]
   assign pc_target = tgt_ff;
   // Second cycle of a taken branch is a forced no-operation
   assign stall = (state_ff == btf_br_flush); // [RQ8]

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   a_wr_in_q4: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en |-> phase == btf_q4) // [RQ5]
      else $error("register write outside Q4");
   a_inv_one_bit: assert property (@(posedge clk_sys) disable iff (rst)
      wr_en |-> $countones(wr_data ^ $past(rd_data, 2)) == 1) // [RQ2]
      else $error("invert changed other than one bit");
   a_inv_decode: assert property (@(posedge clk_sys) disable iff (rst)
      phase == btf_q1 && state_ff == btf_idle && instr_valid
      && instr[15:12] == BTF_OP_INVERT |-> ##3 wr_en) // [RQ1]
      else $error("invert not written back");
   a_bank_addr: assert property (@(posedge clk_sys) disable iff (rst)
      phase == btf_q1 && state_ff == btf_idle && instr_valid
      && instr[15:12] == BTF_OP_INVERT && instr[BTF_A_BIT]
      |=> reg_addr == {$past(bank_select_reg), $past(instr[7:0])}) // [RQ3]
      else $error("banked address wrong");
   a_idx_addr: assert property (@(posedge clk_sys) disable iff (rst)
      phase == btf_q1 && state_ff == btf_idle && instr_valid
      && instr[15:12] == BTF_OP_INVERT && !instr[BTF_A_BIT] && ext_set_en
      && instr[7:0] <= BTF_IDX_MAX
      |=> reg_addr == $past(index_base) + {4'h0, $past(instr[7:0])}) // [RQ4]
      else $error("indexed address wrong");
   a_ovf_target: assert property (@(posedge clk_sys) disable iff (rst)
      phase == btf_q1 && state_ff == btf_idle && instr_valid
      && instr[15:8] == BTF_OP_OVF_BR && flag_ovf
      ##1 flag_ovf ##1 1'b1 |=> pc_load
      && pc_target == $past(pc_next, 3) + $past(offs2, 3)) // [RQ7] [RQ6]
      else $error("overflow branch target wrong");
   a_zero_skip: assert property (@(posedge clk_sys) disable iff (rst)
      phase == btf_q1 && state_ff == btf_idle && instr_valid
      && instr[15:8] == BTF_OP_ZERO_BR ##1 !flag_zero ##1 1'b1
      |=> !pc_load ##1 !stall) // [RQ9] [RQ10] [RQ11]
      else $error("untaken zero branch acted");
   a_taken_flush: assert property (@(posedge clk_sys) disable iff (rst)
      pc_load |=> stall [*4] ##1 !stall) // [RQ8]
      else $error("taken branch flush not four phases");
   a_flag_sample: assert property (@(posedge clk_sys) disable iff (rst)
      state_ff == btf_br_taken && phase == btf_q3
      |-> take_ff == (instr[15:8] == BTF_OP_OVF_BR ? $past(flag_ovf)
                      : $past(flag_zero))) // [RQ12]
      else $error("flag sample wrong");
   c_invert: cover property (@(posedge clk_sys) disable iff (rst) wr_en);
   c_taken: cover property (@(posedge clk_sys) disable iff (rst) stall);
   c_zero_taken: cover property (@(posedge clk_sys) disable iff (rst)
      pc_load && instr[15:8] == BTF_OP_ZERO_BR);
   c_untaken: cover property (@(posedge clk_sys) disable iff (rst)
      state_ff == btf_br_taken && phase == btf_q4 && !take_ff);
endmodule

//--- shared/btf_pkg.sv
// Constants and types for the bit-invert and flag-branch execute unit.
// Assumes one instruction-cycle clock domain shared with the core.
// ---------------------------------------------------------------
// What this block does
// RQ1: Bit-invert opcode is upper nibble 0111
// RQ2: Invert one bit, write back, flags untouched
// RQ3: Selector 0 access bank, 1 bank register
// RQ4: Extended set, selector 0, address<=95: indexed
// RQ5: Bit-invert finishes in one four-phase cycle
// RQ6: Overflow branch opcode is upper byte E4
// RQ7: Overflow set: PC = PC+2 plus twice offset
// RQ8: Taken branch takes two cycles, second idle
// RQ9: Untaken branch one cycle, PC sequential
// RQ10: Zero branch opcode is upper byte E0
// RQ11: Zero set: branch by twice signed offset
// RQ12: Flags sampled at processing phase start
// ---------------------------------------------------------------
package btf_pkg;
   localparam int BTF_PC_W = 21;
   localparam int BTF_ADDR_W = 12;
   localparam logic [3:0] BTF_OP_INVERT = 4'h7;
   localparam logic [7:0] BTF_OP_OVF_BR = 8'hE4;
   localparam logic [7:0] BTF_OP_ZERO_BR = 8'hE0;
   localparam logic [7:0] BTF_IDX_MAX = 8'h5F;
   localparam logic [7:0] BTF_ACC_SPLIT = 8'h60;
   localparam logic [3:0] BTF_ACC_HI_BANK = 4'hF;
   localparam logic [BTF_PC_W-1:0] BTF_PC_STEP = 21'h000002;
   localparam int BTF_BIT_LO = 9;
   localparam int BTF_A_BIT = 8;
   // Four quarter phases of one instruction cycle
   typedef enum logic [1:0] {
      btf_q1, btf_q2, btf_q3, btf_q4
   } btf_phase_e;
   typedef enum logic [1:0] {
      btf_idle, btf_inv, btf_br_taken, btf_br_flush
   } btf_state_e;
endpackage

//--- rtl/btf_phase.sv
// Quarter-phase sequencer for the instruction cycle.
// Assumes clk_sys steps one phase per edge after reset.
`timescale 1ns/1ps
module btf_phase
   import btf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   output btf_pkg::btf_phase_e phase
);
   btf_phase_e phase_ff;
   btf_phase_e nxt_phase;
   always_comb begin
      unique case (phase_ff)
         btf_q1: nxt_phase = btf_q2;
         btf_q2: nxt_phase = btf_q3;
         btf_q3: nxt_phase = btf_q4;
         btf_q4: nxt_phase = btf_q1;
      endcase
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase_ff <= btf_q1;
      end else begin
         phase_ff <= nxt_phase;
      end
   end
   assign phase = phase_ff;
   a_phase_order: assert property (@(posedge clk_sys) disable iff (rst)
      phase_ff == btf_q4 |=> phase_ff == btf_q1) // [RQ5]
      else $error("phase did not wrap");
endmodule

//--- verif/btf_core_model.sv
// Behavioural model of the core register file facing the execute unit.
// Assumes reads are combinational on rd_en and writes land on clk_sys.
`timescale 1ns/1ps
module btf_core_model
   import btf_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [btf_pkg::BTF_ADDR_W-1:0] reg_addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:4095];
   logic [7:0] last_ff;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
      last_ff = 8'h00;
   end
   // Unselected bus shows inverted data so a stale sample cannot pass
   always_comb begin
      rd_data = rd_en ? mem[reg_addr] : ~last_ff;
   end
   always @(posedge clk_sys) begin
      if (rd_en) begin
         last_ff <= mem[reg_addr];
      end
      if (wr_en) begin
         mem[reg_addr] <= wr_data;
      end
   end
endmodule

//--- verif/bit_toggle_and_flag_branch_tb_top.sv
// Self-checking bench for the bit-invert and flag-branch execute unit.
// Assumes the core model above answers register reads and writes.
`timescale 1ns/1ps
module bit_toggle_and_flag_branch_tb_top;
   import btf_pkg::*;
   typedef struct packed {
      logic [15:0] ins;
      logic [3:0] bank;
      logic ext, ovf, zro;
      logic [1:0] kind; // 1 invert, 2 taken, 3 untaken, 0 ignored
      logic [11:0] adr;
      logic [20:0] tgt;
   } btf_row_s;
   logic clk_sys = 1'b0, rst = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
   logic flag_ovf = 1'b0, flag_zero = 1'b0, rd_en, wr_en, pc_load, stall;
   logic [15:0] instr = 16'h0000;
   logic [3:0] bank_select_reg = 4'h0;
   logic [7:0] rd_data, wr_data;
   logic [BTF_ADDR_W-1:0] reg_addr;
   logic [BTF_PC_W-1:0] pc_target;
   logic [1:0] phase_out;
   int n_errors = 0, n_tests = 0;
   btf_row_s rows [10] = '{
      '{16'h7FFF, 4'h3, 1'b0, 1'b0, 1'b0, 2'h1, 12'h3FF, 21'h0},
      '{16'h7060, 4'h0, 1'b1, 1'b0, 1'b0, 2'h1, 12'hF60, 21'h0},
      '{16'h785F, 4'h0, 1'b1, 1'b0, 1'b0, 2'h1, 12'h28F, 21'h0},
      '{16'h745F, 4'h0, 1'b0, 1'b1, 1'b1, 2'h1, 12'h05F, 21'h0},
      '{16'hE480, 4'h0, 1'b0, 1'b1, 1'b0, 2'h2, 12'h0, 21'h000F00},
      '{16'hE47F, 4'h0, 1'b0, 1'b1, 1'b0, 2'h2, 12'h0, 21'h0010FE},
      '{16'hE410, 4'h0, 1'b0, 1'b0, 1'b1, 2'h3, 12'h0, 21'h0},
      '{16'hE0FF, 4'h0, 1'b0, 1'b0, 1'b1, 2'h2, 12'h0, 21'h000FFE},
      '{16'hE005, 4'h0, 1'b0, 1'b1, 1'b0, 2'h3, 12'h0, 21'h0},
      '{16'hE100, 4'h0, 1'b0, 1'b1, 1'b1, 2'h0, 12'h0, 21'h0}};
   btf_exec btf_exec_inst (.clk_sys(clk_sys), .rst(rst), .instr(instr),
      .instr_valid(instr_valid), .pc_next(21'h001000),
      .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en),
      .index_base(12'h230), .flag_ovf(flag_ovf), .flag_zero(flag_zero),
      .rd_data(rd_data), .reg_addr(reg_addr), .rd_en(rd_en),
      .wr_en(wr_en), .wr_data(wr_data), .pc_load(pc_load),
      .pc_target(pc_target), .stall(stall), .phase_out(phase_out));
   btf_core_model btf_core_model_inst (.clk_sys(clk_sys),
      .reg_addr(reg_addr), .rd_en(rd_en), .wr_en(wr_en),
      .wr_data(wr_data), .rd_data(rd_data));
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask
   function automatic logic [7:0] seed_byte(input logic [11:0] a);
      return a[7:0] ^ 8'h5A;
   endfunction
   // Issue at Q1, watch its cycle and the following one
   task automatic run_row(input btf_row_s r, input logic flip,
                          input logic [7:0] wd);
      int k;
      k = 0;
      do begin
         @(posedge clk_sys);
         #1;
         k++;
      end while (phase_out !== 2'd3 && k < 20);
      if (k >= 20) begin
         chk(1'b0, "phase sequencer stuck");
         print_verdict();
      end
      @(posedge clk_sys);
      instr <= r.ins;
      instr_valid <= 1'b1;
      bank_select_reg <= r.bank;
      ext_set_en <= r.ext;
      flag_ovf <= r.ovf;
      flag_zero <= r.zro;
      for (k = 1; k < 8; k++) begin
         @(posedge clk_sys);
         // Flags flipped only after the sampling edge
         if (k == 2 && flip) begin
            flag_ovf <= ~r.ovf;
            flag_zero <= ~r.zro;
         end
         if (k == 4) begin
            instr_valid <= 1'b0;
         end
         #1;
         if (k == 1) chk(rd_en === (r.kind == 2'h1), "read strobe");
         if (k == 3) begin
            chk(wr_en === (r.kind == 2'h1), "write strobe");
            if (r.kind == 2'h1) begin
               chk(reg_addr === r.adr, "inv addr");
               chk(wr_data === wd, "inv data");
            end
            chk(pc_load === (r.kind == 2'h2), "pc load");
            if (r.kind == 2'h2) begin
               chk(pc_target === r.tgt, "target");
            end
         end
         if (k >= 4) chk(stall === (r.kind == 2'h2), "stall");
      end
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] wd;
      btf_row_s hr;
      repeat (16) @(posedge clk_sys);
      #1;
      chk(!pc_load && !wr_en && !stall && !rd_en, "reset strobes");
      chk(phase_out === 2'd0, "reset phase");
      @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) begin
         wd = seed_byte(rows[i].adr) ^ (8'h01 << rows[i].ins[11:9]);
         run_row(rows[i], 1'b0, wd);
         $display("row %0d done", i);
      end
      // Second invert of the same bit restores the byte
      run_row(rows[0], 1'b0, seed_byte(12'h3FF));
      // Late flag edges must not change the decision
      hr = '{16'hE410, 4'h0, 1'b0, 1'b1, 1'b0, 2'h2, 12'h0, 21'h001020};
      run_row(hr, 1'b1, 8'h00);
      hr = '{16'hE005, 4'h0, 1'b0, 1'b1, 1'b0, 2'h3, 12'h0, 21'h0};
      run_row(hr, 1'b1, 8'h00);
      $display("hand cases done");
      // Reset cutting an invert in Q2: no write may follow
      @(posedge clk_sys);
      instr <= rows[0].ins;
      bank_select_reg <= rows[0].bank;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b1;
      instr_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(!pc_load && !wr_en && !stall && !rd_en, "mid-run strobes");
      chk(phase_out === 2'd0, "mid-run phase");
      @(posedge clk_sys);
      rst <= 1'b0;
      // Byte still holds its restored value, so one flip is expected
      wd = seed_byte(rows[0].adr) ^ 8'h80;
      run_row(rows[0], 1'b0, wd);
      $display("reset case done");
      print_verdict();
   end
endmodule
